// ===== verilog/dpg_pkg.sv
/*
 * Shared constants and carrier types for the demonstration pulse
 * pattern generator: time base, group shapes, burst and single-shot
 * timing.
 * Assumes a 100 MHz core clock and a 25 ns pattern tick.
 */
package dpg_pkg;

	// ==========================================================
	// Time base
	// ==========================================================
	localparam int CLK_PERIOD_NS = 10;      // Core clock period
	localparam int TICK_NS       = 25;      // Pattern tick period
	localparam int TICK_GCD      = 5;       // Common divisor of both
	localparam int ACC_STEP      = CLK_PERIOD_NS / TICK_GCD;
	localparam int ACC_MOD       = TICK_NS / TICK_GCD;
	localparam int ACC_W         = 3;       // Phase accumulator width

	// ==========================================================
	// Pulse train groups
	// ==========================================================
	localparam int GROUP_PERIOD_NS = 1600;  // Group repeat period
	localparam int GROUP_TICKS     = GROUP_PERIOD_NS / TICK_NS;
	localparam int POS_W           = $clog2(GROUP_TICKS);
	localparam int FREQUENT_GLITCH_TRAIN_OUT_NS    = 104857600; // Frequent anomaly period
	localparam int RARE_GLITCH_TRAIN_OUT_NS    = 838860800; // Rare anomaly period
	localparam int FREQUENT_GLITCH_TRAIN_OUT_GROUPS = FREQUENT_GLITCH_TRAIN_OUT_NS / GROUP_PERIOD_NS;
	localparam int RARE_GLITCH_TRAIN_OUT_GROUPS = RARE_GLITCH_TRAIN_OUT_NS / GROUP_PERIOD_NS;

	// Bit i is the level during tick i of a group
	localparam logic [GROUP_TICKS-1:0] NORMAL_LEVEL =
		64'h0000_0000_00f0_ff0f;           // 100/200/100 ns highs
	localparam logic [GROUP_TICKS-1:0] FREQ_LEVEL =
		64'h0000_0000_00f0_f30f;           // 100,50,100,100 highs
	localparam logic [GROUP_TICKS-1:0] FREQ_RUNT =
		64'h0000_0000_0000_f000;           // Third pulse is runt
	localparam logic [GROUP_TICKS-1:0] RARE_LEVEL =
		64'h0000_0000_000f_0f0b;           // 50,25,100,100 highs
	localparam logic [GROUP_TICKS-1:0] RARE_RUNT =
		64'h0000_0000_0000_0f00;           // Third pulse is runt

	// ==========================================================
	// Random burst
	// ==========================================================
	localparam int BURST_PERIOD_NS = 6600000; // Burst repeat period
	localparam int BURST_LEN_NS    = 6320;    // Burst duration
	localparam int BIT_NS          = 100;     // One burst bit
	localparam int BIT_TICKS       = BIT_NS / TICK_NS;
	localparam int BURST_BITS      = BURST_LEN_NS / BIT_NS;
	localparam int BIT_SUB_W       = $clog2(BIT_TICKS);
	localparam int BIT_IDX_W       = $clog2(BURST_BITS);
	localparam int BCNT_W          = 7;       // 128 distinct bursts
	localparam int LFSR_W          = 15;
	localparam logic [7:0] LFSR_SEED_LO = 8'h01; // Keeps seed nonzero

	// ==========================================================
	// Single shot
	// ==========================================================
	localparam int SS_WIDTH_NS = 200;
	localparam int SS_CYCLES   = SS_WIDTH_NS / CLK_PERIOD_NS;
	localparam int SS_W        = $clog2(SS_CYCLES);

	// Burst sequencer states
	typedef enum logic [1:0] {
		BURST_IDLE   = 2'b01,
		BURST_ACTIVE = 2'b10
	} dpg_burst_e;

	// One pulse train output: level plus half-height select
	typedef struct packed {
		logic level;
		logic runt;
	} dpg_train_out_s;

endpackage

// ===== verilog/dpg_train.sv
/*
 * One pulse train shaper: looks up the level and runt select for the
 * current tick of a group, normal or anomalous.
 * Assumes the group position and anomaly flag come from the same
 * clock domain.
 */
`timescale 1ns/100ps
module dpg_train import dpg_pkg::*; #(
	parameter logic [GROUP_TICKS-1:0] ANOM_LEVEL = FREQ_LEVEL,
	parameter logic [GROUP_TICKS-1:0] ANOM_RUNT  = FREQ_RUNT
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [POS_W-1:0] pos,
	input  wire logic             anom,
	output dpg_train_out_s        train
);

	// ==========================================================
	// State
	// ==========================================================
	dpg_train_out_s s_d;   // Next output
	dpg_train_out_s s_q;   // Registered output

	// Pattern lookup
	always_comb begin
		s_d = s_q;
		if (ce) begin
			if (anom) begin
				s_d.level = ANOM_LEVEL[pos];
				s_d.runt  = ANOM_RUNT[pos];
			end else begin
				s_d.level = NORMAL_LEVEL[pos];
				s_d.runt  = 1'b0;
			end
		end
	end

	// Register
	always_ff @(posedge clk) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign train = s_q;

	// ==========================================================
	// Checks
	// ==========================================================
	property p_runt_high;
		@(posedge clk) disable iff (rst)
		s_q.runt |-> s_q.level;
	endproperty
	a_runt_high: assert property (p_runt_high)
		else $error("Runt select without high level");

	property p_normal_shape;
		@(posedge clk) disable iff (rst)
		(ce && !anom) |=> (s_q.level == $past(NORMAL_LEVEL[pos]))
			&& !s_q.runt;
	endproperty
	a_normal_shape: assert property (p_normal_shape)
		else $error("Normal group level mismatch");

endmodule

// ===== verilog/dpg_top.sv
/*
 * Demonstration pulse pattern generator: two anomaly pulse trains,
 * a pseudorandom burst output and a push-button single-shot pulse.
 * Assumes a 100 MHz clock, a synchronous reset and a raw button pin.
 */
//
// Overview of operation
// - Normal group: 100, 200, 100 ns highs
// - Group restarts every 1.6 us continuously
// - Frequent anomaly group every 104.8 ms
// - Frequent group: 100,50,100 runt,100 ns
// - Frequent narrow pulse every 104.8 ms
// - Rare anomaly group every 838.8 ms
// - Rare narrow 25 ns pulse, same group
// - Rare group: 50,25,100 runt,100 ns
// - Burst of 100 ns pulses every 6.6 ms
// - Pseudorandom bursts repeat after 128, 6.3 us
// - Button press gives one 200 ns pulse
// - One pulse per press, otherwise low
`timescale 1ns/100ps
module dpg_top import dpg_pkg::*; #(
	parameter int FREQ_GROUPS   = FREQUENT_GLITCH_TRAIN_OUT_GROUPS,
	parameter int RARE_GROUPS   = RARE_GLITCH_TRAIN_OUT_GROUPS,
	parameter int BURST_PERIOD  = BURST_PERIOD_NS / TICK_NS
) (
	input  wire logic CORE_CLK,
	input  wire logic SYS_RST,
	input  wire logic CORE_CE,
	input  wire logic SS_BUTTON,
	output logic      FREQUENT_GLITCH_TRAIN_OUT,
	output logic      FREQUENT_RUNT_SEL,
	output logic      RARE_GLITCH_TRAIN_OUT,
	output logic      RARE_RUNT_SEL,
	output logic      RANDOM_BURST_OUT,
	output logic      SINGLE_SHOT_OUT
);

	localparam int GW = $clog2(RARE_GROUPS);   // Group counter width
	localparam int BW = $clog2(BURST_PERIOD);  // Burst timer width

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [ACC_W-1:0]     acc;      // Tick phase accumulator
		logic [POS_W-1:0]     pos;      // Tick within group
		logic [GW-1:0]        grp;      // Group counter
		logic [BW-1:0]        btimer;   // Ticks since burst start
		dpg_burst_e           bstate;   // Burst sequencer
		logic [BIT_IDX_W-1:0] bidx;     // Bit within burst
		logic [BIT_SUB_W-1:0] bsub;     // Tick within bit
		logic [LFSR_W-1:0]    lfsr;     // Burst bit source
		logic [BCNT_W-1:0]    bcnt;     // Burst number
		logic                 burst;    // Burst output
		logic [1:0]           btn_sync; // Button synchroniser
		logic                 btn_prev; // Previous synced level
		logic [SS_W-1:0]      ss_cnt;   // Single-shot width count
		logic                 ss;       // Single-shot output
	} dpg_top_state_s;

	dpg_top_state_s s_d;       // Next state
	dpg_top_state_s s_q;       // Registered state
	logic           tick;      // One 25 ns tick
	logic           press;     // Button rising edge
	logic           anom_freq; // Frequent anomaly group now
	logic           anom_rare; // Rare anomaly group now
	dpg_train_out_s freq_tr;   // Frequent train outputs
	dpg_train_out_s rare_tr;   // Rare train outputs

	// True in the last group of each n-group period
	function automatic logic is_last(input logic [GW-1:0] c,
					 input int n);
		return ((int'(c) % n) == (n - 1));
	endfunction

	// Tick fires when the accumulator would overflow
	assign tick  = CORE_CE && (int'(s_q.acc) >= ACC_MOD - ACC_STEP);
	assign press = s_q.btn_sync[1] && !s_q.btn_prev;
	assign anom_freq = is_last(s_q.grp, FREQ_GROUPS);
	assign anom_rare = is_last(s_q.grp, RARE_GROUPS);

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		s_d = s_q;
		if (CORE_CE) begin
			// 2/5 phase step gives 40 MHz average ticks
			if (tick)
				s_d.acc = ACC_W'(int'(s_q.acc) + ACC_STEP - ACC_MOD);
			else
				s_d.acc = ACC_W'(int'(s_q.acc) + ACC_STEP);
			s_d.btn_sync = {s_q.btn_sync[0], SS_BUTTON};
			s_d.btn_prev = s_q.btn_sync[1];

			// Group position and group count
			if (tick) begin
				if (int'(s_q.pos) == GROUP_TICKS - 1) begin
					s_d.pos = '0;
					if (int'(s_q.grp) == RARE_GROUPS - 1)
						s_d.grp = '0;
					else
						s_d.grp = s_q.grp + 1'b1;
				end else begin
					s_d.pos = s_q.pos + 1'b1;
				end
			end

			// Burst period timer and sequencer
			if (tick) begin
				if (int'(s_q.btimer) == BURST_PERIOD - 1) begin
					s_d.btimer = '0;
					s_d.bstate = BURST_ACTIVE;
					s_d.bidx   = '0;
					s_d.bsub   = '0;
					s_d.lfsr   = {s_q.bcnt, LFSR_SEED_LO};
					s_d.bcnt   = s_q.bcnt + 1'b1;
				end else begin
					s_d.btimer = s_q.btimer + 1'b1;
					case (s_q.bstate)
						BURST_IDLE: begin
							// Output idles low between bursts
						end
						BURST_ACTIVE: begin
							if (int'(s_q.bsub) == BIT_TICKS - 1) begin
								s_d.bsub = '0;
								s_d.lfsr = {s_q.lfsr[LFSR_W-2:0],
									s_q.lfsr[LFSR_W-1] ^
									s_q.lfsr[LFSR_W-2]};
								// Burst ends after its last bit
								if (int'(s_q.bidx) == BURST_BITS - 1)
									s_d.bstate = BURST_IDLE;
								else
									s_d.bidx = s_q.bidx + 1'b1;
							end else begin
								s_d.bsub = s_q.bsub + 1'b1;
							end
						end
						default: s_d.bstate = BURST_IDLE;
					endcase
				end
			end
			// 100 ns bit slots driven from the sequence
			s_d.burst = (s_d.bstate == BURST_ACTIVE) && s_d.lfsr[0];

			// Single shot: edge starts it, count ends it
			if (s_q.ss) begin
				if (int'(s_q.ss_cnt) == SS_CYCLES - 1)
					s_d.ss = 1'b0;
				else
					s_d.ss_cnt = s_q.ss_cnt + 1'b1;
			end else if (press) begin
				s_d.ss     = 1'b1;
				s_d.ss_cnt = '0;
			end
		end
	end

	// Register all state
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			s_q        <= '0;
			s_q.bstate <= BURST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Pulse trains
	// ==========================================================
	// Frequent group shape
	dpg_train #(
		.ANOM_LEVEL (FREQ_LEVEL),
		.ANOM_RUNT  (FREQ_RUNT)
	) u_freq (
		.clk   (CORE_CLK),
		.rst   (SYS_RST),
		.ce    (CORE_CE),
		.pos   (s_q.pos),
		.anom  (anom_freq),
		.train (freq_tr)
	);

	// Rare group shape
	dpg_train #(
		.ANOM_LEVEL (RARE_LEVEL),
		.ANOM_RUNT  (RARE_RUNT)
	) u_rare (
		.clk   (CORE_CLK),
		.rst   (SYS_RST),
		.ce    (CORE_CE),
		.pos   (s_q.pos),
		.anom  (anom_rare),
		.train (rare_tr)
	);

	assign FREQUENT_GLITCH_TRAIN_OUT = freq_tr.level;
	assign FREQUENT_RUNT_SEL         = freq_tr.runt;
	assign RARE_GLITCH_TRAIN_OUT     = rare_tr.level;
	assign RARE_RUNT_SEL             = rare_tr.runt;
	assign RANDOM_BURST_OUT          = s_q.burst;
	assign SINGLE_SHOT_OUT           = s_q.ss;

	// ==========================================================
	// Checks
	// ==========================================================
	property p_tick_spacing;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		tick |=> !tick;
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("Ticks closer than two cycles");

	property p_group_wrap;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(tick && int'(s_q.pos) == GROUP_TICKS - 1) |=> (s_q.pos == '0);
	endproperty
	a_group_wrap: assert property (p_group_wrap)
		else $error("Group did not restart");

	// Anomaly replaces one group only, then normal groups return
	property p_frequent_glitch_train_out;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(anom_freq && tick && int'(s_q.pos) == GROUP_TICKS - 1)
			|=> !anom_freq;
	endproperty
	a_frequent_glitch_train_out: assert property (p_frequent_glitch_train_out)
		else $error("Frequent anomaly in wrong group");

	// The rare group closes the group count cycle
	property p_rare_last;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(anom_rare && tick && int'(s_q.pos) == GROUP_TICKS - 1)
			|=> (s_q.grp == '0) && !anom_rare;
	endproperty
	a_rare_last: assert property (p_rare_last)
		else $error("Rare anomaly not at end of count");

	property p_burst_start;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(tick && int'(s_q.btimer) == BURST_PERIOD - 1)
			|=> (s_q.bstate == BURST_ACTIVE) && (s_q.btimer == '0);
	endproperty
	a_burst_start: assert property (p_burst_start)
		else $error("Burst did not start on period");

	property p_burst_len;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		(s_q.bstate == BURST_ACTIVE) |-> (int'(s_q.bidx) < BURST_BITS);
	endproperty
	a_burst_len: assert property (p_burst_len)
		else $error("Burst ran past its length");

	sequence s_press_seen;
		CORE_CE && press && !s_q.ss;
	endsequence

	property p_ss_start;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		$rose(s_q.ss) |-> $past(press);
	endproperty
	a_ss_start: assert property (p_ss_start)
		else $error("Single shot without a press");

	// High for 8 + 8 + 4 cycles, the whole single-shot width
	sequence s_ss_held;
		s_q.ss [*8] ##1 s_q.ss [*8] ##1 s_q.ss [*4];
	endsequence

	property p_ss_width;
		@(posedge CORE_CLK) disable iff (SYS_RST || !CORE_CE)
		s_press_seen |=> s_ss_held ##1 !s_q.ss;
	endproperty
	a_ss_width: assert property (p_ss_width)
		else $error("Single shot width wrong");

endmodule

// ===== verification/dpg_probe.sv
/*
 * Scope probe model: watches one output line and logs the lengths of
 * its high and low runs, counted in core clock cycles.
 * Assumes the line is registered on the rising edge of the clock.
 */
`timescale 1ns/100ps
module dpg_probe (
	input wire logic clk,
	input wire logic arm,
	input wire logic sig
);
	// ==========================================================
	// Run log
	// ==========================================================
	int   runs[$];   // Plus n for a high run, minus n for a low run
	int   len;       // Cycles seen in the current run
	logic lvl;       // Level of the current run

	// Sample mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (!arm) begin
			len = 0;
			lvl = sig;
		end else if (sig !== lvl) begin
			// Level changed: close the run just ended
			runs.push_back(lvl ? len : -len);
			len = 1;
			lvl = sig;
		end else begin
			len++;
		end
	end
endmodule

// ===== verification/tb.sv
/*
 * Self-checking bench: pulse trains, runt selects, burst framing and
 * the single-shot pulse.
 * Assumes the shortened group and burst counts set below.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
	bad_count++; $display("unexpected %0t: got %0d expected %0d", \
	$time, got, exp); end end
module tb import dpg_pkg::*; ;
	// ==========================================================
	// Design and probes
	// ==========================================================
	logic clk    = 1'b0;  // Core clock
	logic rst    = 1'b1;  // Synchronous reset
	logic ce     = 1'b1;  // Clock enable
	logic button = 1'b0;  // Single-shot button pin
	logic arm    = 1'b0;  // Probe capture window
	logic f_out, f_runt, r_out, r_runt, b_out, ss_out;
	int   bad_count = 0;
	int   checked   = 0;
	logic ss_on     = 1'b0;  // Single-shot tally window
	logic ss_prev   = 1'b0;
	int   ss_rises, ss_high, ss_age, ss_first;
	int   pat_norm[] = '{10, -10, 20, -10, 10, -100};
	int   pat_freq[] = '{10, -10, 5, -5, 10, -10, 10, -100};
	int   pat_rare[] = '{5, -1, 1, -10, 10, -10, 10, -110};
	int   pat_runt[] = '{10};

	dpg_top #(.FREQ_GROUPS(4), .RARE_GROUPS(16), .BURST_PERIOD(400)) uut (
		.CORE_CLK                  (clk),
		.SYS_RST                   (rst),
		.CORE_CE                   (ce),
		.SS_BUTTON                 (button),
		.FREQUENT_GLITCH_TRAIN_OUT (f_out),
		.FREQUENT_RUNT_SEL         (f_runt),
		.RARE_GLITCH_TRAIN_OUT     (r_out),
		.RARE_RUNT_SEL             (r_runt),
		.RANDOM_BURST_OUT          (b_out),
		.SINGLE_SHOT_OUT           (ss_out)
	);
	dpg_probe p_freq (.clk(clk), .arm(arm), .sig(f_out));
	dpg_probe p_rare (.clk(clk), .arm(arm), .sig(r_out));
	dpg_probe p_frs  (.clk(clk), .arm(arm), .sig(f_runt));
	dpg_probe p_rrs  (.clk(clk), .arm(arm), .sig(r_runt));
	dpg_probe p_brst (.clk(clk), .arm(arm), .sig(b_out));

	// 100 MHz clock
	always #5 clk = ~clk;

	// Runt select only ever marks a high pulse
	always @(negedge clk) begin
		if (arm && f_runt === 1'b1)
			`CHK(f_out, 1'b1)
		if (arm && r_runt === 1'b1)
			`CHK(r_out, 1'b1)
	end

	// Tally single-shot pulses while a case runs
	always @(negedge clk) begin
		if (ss_on) begin
			ss_age++;
			ss_high += (ss_out === 1'b1);
			if (ss_out === 1'b1 && ss_prev !== 1'b1) begin
				ss_rises++;
				if (ss_rises == 1)
					ss_first = ss_age;
			end
		end
		ss_prev = ss_out;
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	// Step n cycles, landing just after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Count places where the run log matches a pattern; 1 or -1 is a
	// single tick, which lasts two or three cycles
	function automatic int count_seq(input int q[$], input int p[]);
		int hits;
		int ok;
		hits = 0;
		for (int i = 0; i + p.size() <= q.size(); i++) begin
			ok = 1;
			foreach (p[j]) begin
				if (p[j] == 1 || p[j] == -1)
					ok &= (q[i+j] * p[j] inside {2, 3});
				else
					ok &= (q[i+j] == p[j]);
			end
			hits += ok;
		end
		return hits;
	endfunction

	// ==========================================================
	// Scenarios
	// ==========================================================
	// Groups 2 to 22 lie whole inside the capture window
	task automatic check_trains();
		`CHK(count_seq(p_freq.runs, pat_norm), 16)
		`CHK(count_seq(p_freq.runs, pat_freq), 5)
		`CHK(count_seq(p_rare.runs, pat_norm), 20)
		`CHK(count_seq(p_rare.runs, pat_rare), 1)
		`CHK(count_seq(p_frs.runs, pat_runt), 6)
		`CHK(count_seq(p_rrs.runs, pat_runt), 1)
	endtask

	// Bursts every 1000 cycles, 100 ns bits, at most 630 cycles long
	task automatic check_burst();
		int t;
		int start;
		int last;
		int n;
		int r;
		t = 0;
		start = 0;
		last = 0;
		n = 0;
		foreach (p_brst.runs[i]) begin
			r = p_brst.runs[i];
			if (r > 0) begin
				`CHK(r % 10, 0)
				`CHK(t + r - start <= 630, 1'b1)
			end else if (-r >= 370) begin
				start = t - r;
				if (n > 0)
					`CHK(start - last, 1000)
				last = start;
				n++;
			end else begin
				`CHK((-r) % 10, 0)
			end
			t += (r > 0) ? r : -r;
		end
		`CHK(n, 3)
	endtask

	// Press, optional freeze, optional second press, then judge
	task automatic ss_case(input int h1, input int gap, input int off,
			input int h2, input int np, input int nh);
		ss_rises = 0;
		ss_high = 0;
		ss_age = 0;
		ss_first = 0;
		ss_on = 1'b1;
		button = 1'b1;
		cyc(h1);
		button = 1'b0;
		cyc(gap);
		if (off > 0) begin
			ce = 1'b0;
			cyc(off);
			ce = 1'b1;
		end
		if (h2 > 0) begin
			button = 1'b1;
			cyc(h2);
			button = 1'b0;
		end
		cyc(120);
		ss_on = 1'b0;
		`CHK(ss_rises, np)
		`CHK(ss_high, nh)
		`CHK(ss_first inside {[3:6]}, 1'b1)
	endtask

	// Verdict and end of run
	task automatic end_of_test();
		$display("Mismatches %0d of %0d comparisons", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence and watchdog
	// ==========================================================
	initial begin
		cyc(9);
		`CHK({f_out, f_runt, r_out, r_runt, b_out, ss_out}, 6'h00)
		cyc(1);
		rst = 1'b0;
		cyc(240);
		arm = 1'b1;
		cyc(3560);
		arm = 1'b0;
		check_trains();
		check_burst();
		ss_case(100, 0, 0, 0, 1, SS_CYCLES);
		ss_case(3, 6, 0, 3, 1, SS_CYCLES);
		ss_case(3, 40, 0, 3, 2, 2 * SS_CYCLES);
		ss_case(3, 10, 15, 0, 1, SS_CYCLES + 15);
		end_of_test();
	end

	// Whole run needs about 4480 cycles
	initial begin
		#200000;
		bad_count++;
		$display("unexpected %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule
